// >>> hdl/panel_pkg.sv
package panel_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned STEP_MS = 300;
  localparam int unsigned IDLE_MS = 2000;
  localparam int unsigned DROP_MS = 20;
  localparam int unsigned FLASH_MS = 200;
  localparam int unsigned BOOT_MS = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned STEP_CYCLES = STEP_MS * CYC_PER_MS;
  localparam int unsigned MIN_STEP_CYCLES = STEP_CYCLES / 8;
  localparam int unsigned IDLE_CYCLES = IDLE_MS * CYC_PER_MS;
  localparam int unsigned DROP_CYCLES = DROP_MS * CYC_PER_MS;
  localparam int unsigned FLASH_CYCLES = FLASH_MS * CYC_PER_MS;
  localparam int unsigned BOOT_CYCLES = BOOT_MS * CYC_PER_MS;
  localparam logic [1:0] ACCEL_EVERY = 2'h3;
  // Voltage in 0.1 V units, frequency in Hz, current in 0.1 A units.
  localparam logic [11:0] VMAX_HI = 12'hBB8;
  localparam logic [11:0] VMAX_LO = 12'h5DC;
  localparam logic [11:0] FREQ_PRESET = 12'h190;
  localparam logic [11:0] FREQ_MIN = 12'h168;
  localparam logic [11:0] FREQ_MAX = 12'h1B8;
  localparam logic [11:0] ILIM_OFF = 12'h000;
  localparam logic [15:0] OVERCURRENT_TRIP_CODE = 16'h00C1;
  localparam int unsigned NPIN = 11;
  localparam logic [3:0] PIN_VUP = 4'h0;
  localparam logic [3:0] PIN_VDN = 4'h1;
  localparam logic [3:0] PIN_RANGE = 4'h2;
  localparam logic [3:0] PIN_FUP = 4'h3;
  localparam logic [3:0] PIN_FDN = 4'h4;
  localparam logic [3:0] PIN_FPRESET = 4'h5;
  localparam logic [3:0] PIN_IUP = 4'h6;
  localparam logic [3:0] PIN_IDN = 4'h7;
  localparam logic [3:0] PIN_METER = 4'h8;
  localparam logic [3:0] PIN_PHASE = 4'h9;
  localparam logic [3:0] PIN_OVERCUR = 4'hA;
  localparam logic [3:0] PIN_NONE = 4'hF;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FAULT = 8'h04;
  localparam logic [7:0] OFF_VSET = 8'h08;
  localparam logic [7:0] OFF_FSET = 8'h0C;
  localparam logic [7:0] OFF_ILIM = 8'h10;
  localparam logic [7:0] OFF_VLIM = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam int unsigned ST_REJECT = 3;
  localparam logic [3:0] ONEHOT_FIRST = 4'h1;
  typedef enum logic [3:0] {
    ADJ_NONE = 4'b0001,
    ADJ_VOLT = 4'b0010,
    ADJ_FREQ = 4'b0100,
    ADJ_CUR = 4'b1000
  } adj_e;
endpackage

// >>> hdl/panel_setpoint_ctrl.sv
// Overview of operation
// (R1) Voltage up/down buttons adjust the setpoint in standby and while output is on.
// (R2) High range allows 0 to 300 V, low range 0 to 150 V.
// (R3) Held voltage button steps every 0.3 s, faster the longer held.
// (R4) After 2 s unchanged, flash voltage display once, store setpoint, leave setting.
// (R5) Never switch from low to high range without an operator press.
// (R6) Range button toggles ranges, also while on, keeping the voltage setpoint.
// (R7) Range change while output is on drops the output for about 20 ms.
// (R8) Refuse a range change whose target cannot hold the stored voltage limits; the code checks only the lower limit and the setpoint.
// (R9) Frequency up/down works in both modes, 1 Hz per step.
// (R10) Preset button loads 400 Hz at once.
// (R11) Held frequency button steps every 0.3 s, faster the longer held.
// (R12) After 2 s unchanged, flash frequency display once, store, leave setting.
// (R13) On an error shutdown the frequency display shows the error code.
// (R14) First current button press only shows the stored current limit.
// (R15) Later presses adjust it; 2 s unchanged returns to the previous display.
// (R16) Limit at its off value means output capacity limits the current.
// (R17) Meter button cycles power, power factor, time, program step, lighting its LED.
// (R18) Program step view shows set number and step number together.
// (R19) Phase button cycles three phases then the combined view.
// (R20) Combined view averages voltage, current, power factor and totals power.
// (R21) At power-on show model number and firmware version briefly.
// (R22) Coming up from power always enters standby with the output off.
// (R23) Held repeat interval halves every few repeats down to a floor.
// (R24) The confirmation flash blanks the display briefly, then restores it.
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module panel_setpoint_ctrl #(
  parameter int unsigned STEP_CYC = panel_pkg::STEP_CYCLES,
  parameter int unsigned MIN_STEP_CYC = panel_pkg::MIN_STEP_CYCLES,
  parameter int unsigned IDLE_CYC = panel_pkg::IDLE_CYCLES,
  parameter int unsigned DROP_CYC = panel_pkg::DROP_CYCLES,
  parameter int unsigned FLASH_CYC = panel_pkg::FLASH_CYCLES,
  parameter int unsigned BOOT_CYC = panel_pkg::BOOT_CYCLES,
  parameter logic [11:0] RATED_CUR = 12'h0C8,
  // Identity values are arbitrary.
  parameter logic [15:0] MODEL_NUM = 16'h1234,
  parameter logic [15:0] FW_VERSION = 16'h0100
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Wishbone slave
  input wire logic cyc_in,
  input wire logic stb_in,
  input wire logic we_in,
  input wire logic [panel_pkg::ADDR_W-1:0] adr_in,
  input wire logic [3:0] sel_in,
  input wire logic [31:0] dat_in,
  output logic [31:0] dat_out,
  output logic ack_out,
  // Panel buttons and overcurrent trip pin
  input wire logic [panel_pkg::NPIN-1:0] pins_in,
  // Measurements, three phases of 16 bits, phase R in the low bits; then test time and program set and step
  input wire logic [47:0] meas_volt_in,
  input wire logic [47:0] meas_cur_in,
  input wire logic [47:0] meas_pf_in,
  input wire logic [47:0] meas_pow_in,
  input wire logic [15:0] test_time_in,
  input wire logic [3:0] prog_set_in,
  input wire logic [3:0] prog_step_in,
  // Displays and indicators
  output logic [15:0] volt_disp_out,
  output logic [15:0] freq_disp_out,
  output logic [15:0] cur_disp_out,
  output logic [15:0] meter_disp_out,
  output logic volt_blank_out,
  output logic freq_blank_out,
  output logic freq_err_out,
  output logic [1:0] range_led_out,
  output logic [3:0] meter_led_out,
  output logic [3:0] phase_led_out,
  // Power stage controls
  output logic output_on_out,
  output logic [11:0] vset_out,
  output logic [11:0] fset_out,
  output logic [11:0] cur_limit_eff_out
);
  import panel_pkg::*;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] lvl;
    adj_e adj;
    logic [31:0] idle;
    logic [31:0] rep_tmr;
    logic [31:0] rep_int;
    logic [31:0] boot;
    logic [31:0] drop;
    logic [31:0] flash;
    logic [3:0] rep_btn;
    logic [1:0] rep_cnt;
    logic flash_freq;
    logic [11:0] vlive;
    logic [11:0] vstore;
    logic [11:0] vlo_lim;
    logic [11:0] vhi_lim;
    logic [11:0] flive;
    logic [11:0] fstore;
    logic [11:0] ilim;
    logic range_hi;
    logic run;
    logic reject;
    logic [15:0] fault;
    logic [3:0] meter;
    logic [3:0] phase;
    logic ack;
    logic [31:0] rdat;
    logic [15:0] vdisp;
    logic [15:0] fdisp;
    logic [15:0] cdisp;
    logic [15:0] mdisp;
    logic vblank;
    logic fblank;
    logic on;
    logic [11:0] ieff;
    logic ferr;
    logic [1:0] rled;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic [NPIN-1:0] press;
  logic fire;
  logic [3:0] fire_btn;
  logic range_ok;
  logic [31:0] wval;

  function automatic logic [11:0] bump(input logic [11:0] v, input logic up, input logic [11:0] lo,
                                       input logic [11:0] hi);
    if (up) begin
      bump = (v >= hi) ? hi : v + 12'h001;
    end else begin
      bump = (v <= lo) ? lo : v - 12'h001;
    end
  endfunction

  function automatic logic [15:0] pick(input logic [47:0] m, input logic [3:0] ph, input logic total);
    logic [17:0] s;
    s = {2'h0, m[15:0]} + {2'h0, m[31:16]} + {2'h0, m[47:32]};
    if (ph[0]) begin
      pick = m[15:0];
    end else if (ph[1]) begin
      pick = m[31:16];
    end else if (ph[2]) begin
      pick = m[47:32];
    end else if (total) begin
      pick = (s > 18'h0FFFF) ? 16'hFFFF : s[15:0];
    end else begin
      pick = 16'(s / 18'h00003);
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction

  function automatic logic [3:0] rotate(input logic [3:0] v);
    rotate = {v[2:0], v[3]};
  endfunction

  function automatic logic [11:0] min12(input logic [11:0] a, input logic [11:0] b);
    min12 = (a < b) ? a : b;
  endfunction

  always_comb begin
    st_next = st_reg;
    fire = 1'b0;
    fire_btn = PIN_NONE;
    wval = 32'h0000_0000;
    // A change counts only once the second and third stages agree.
    st_next.s1 = pins_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < NPIN; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
    press = st_next.lvl & ~st_reg.lvl;
    // (R21) Power-on banner hold.
    if (st_reg.boot != 32'h0) begin
      st_next.boot = st_reg.boot - 32'h1;
      press = '0;
    end
    if (st_reg.drop != 32'h0) begin
      st_next.drop = st_reg.drop - 32'h1;
    end
    // (R24) Flash blanking interval.
    if (st_reg.flash != 32'h0) begin
      st_next.flash = st_reg.flash - 32'h1;
    end
    // (R3) (R11) (R23) Auto repeat with acceleration.
    if (st_reg.rep_btn != PIN_NONE) begin
      if (!st_next.lvl[st_reg.rep_btn]) begin
        st_next.rep_btn = PIN_NONE;
      end else if (st_reg.rep_tmr <= 32'h1) begin
        fire = 1'b1;
        fire_btn = st_reg.rep_btn;
        st_next.rep_cnt = st_reg.rep_cnt + 2'h1;
        st_next.rep_int = st_reg.rep_int;
        if (st_reg.rep_cnt == ACCEL_EVERY) begin
          st_next.rep_int = ((st_reg.rep_int >> 1) < MIN_STEP_CYC) ? MIN_STEP_CYC : st_reg.rep_int >> 1;
        end
        st_next.rep_tmr = st_next.rep_int;
      end else begin
        st_next.rep_tmr = st_reg.rep_tmr - 32'h1;
      end
    end
    for (int i = int'(PIN_IDN); i >= 0; i--) begin
      if (press[i] && i != int'(PIN_RANGE) && i != int'(PIN_FPRESET)) begin
        fire = 1'b1;
        fire_btn = 4'(i);
      end
    end
    if (fire && fire_btn != st_reg.rep_btn) begin
      st_next.rep_btn = fire_btn;
      st_next.rep_int = STEP_CYC;
      st_next.rep_tmr = STEP_CYC;
      st_next.rep_cnt = 2'h0;
    end
    // (R4) (R12) (R15) Two seconds without change commits and leaves setting.
    if (st_reg.adj != ADJ_NONE) begin
      if (st_reg.idle <= 32'h1) begin
        st_next.adj = ADJ_NONE;
        if (st_reg.adj == ADJ_VOLT) begin
          st_next.vstore = st_reg.vlive;
          st_next.flash = FLASH_CYC;
          st_next.flash_freq = 1'b0;
        end else if (st_reg.adj == ADJ_FREQ) begin
          st_next.fstore = st_reg.flive;
          st_next.flash = FLASH_CYC;
          st_next.flash_freq = 1'b1;
        end
      end else begin
        st_next.idle = st_reg.idle - 32'h1;
      end
    end
    // Stores happen only at a commit or when another kind of adjustment takes over.
    if (fire) begin
      st_next.idle = IDLE_CYC;
      unique case (fire_btn)
        PIN_VUP, PIN_VDN: begin
          // (R1) (R2) Voltage step bounded by range and limits.
          st_next.vlive = bump(st_reg.vlive, fire_btn == PIN_VUP, st_reg.vlo_lim,
                               min12(st_reg.range_hi ? VMAX_HI : VMAX_LO, st_reg.vhi_lim));
          st_next.fstore = st_reg.flive;
          st_next.adj = ADJ_VOLT;
        end
        PIN_FUP, PIN_FDN: begin
          // (R9) One hertz per step.
          st_next.flive = bump(st_reg.flive, fire_btn == PIN_FUP, FREQ_MIN, FREQ_MAX);
          st_next.vstore = st_reg.vlive;
          st_next.adj = ADJ_FREQ;
        end
        default: begin
          // (R14) First press only shows the limit.
          if (st_reg.adj != ADJ_CUR) begin
            st_next.rep_btn = PIN_NONE;
          end else begin
            st_next.ilim = bump(st_reg.ilim, fire_btn == PIN_IUP, ILIM_OFF, RATED_CUR);
          end
          st_next.vstore = st_reg.vlive;
          st_next.fstore = st_reg.flive;
          st_next.adj = ADJ_CUR;
        end
      endcase
    end
    // (R10) Preset loads at once.
    if (press[PIN_FPRESET]) begin
      st_next.flive = FREQ_PRESET;
      st_next.vstore = st_reg.vlive;
      st_next.adj = ADJ_FREQ;
      st_next.idle = IDLE_CYC;
    end
    // (R8) Low range must hold the lower limit and the setpoint.
    range_ok = !st_reg.range_hi || (st_reg.vlo_lim <= VMAX_LO && st_reg.vlive <= VMAX_LO);
    // (R5) (R6) (R7) Range toggles only on a press.
    if (press[PIN_RANGE]) begin
      if (range_ok) begin
        st_next.range_hi = !st_reg.range_hi;
        if (st_reg.run) begin
          st_next.drop = DROP_CYC;
        end
      end else begin
        st_next.reject = 1'b1;
      end
    end
    // (R17) (R19) One-hot view rotation.
    if (press[PIN_METER]) begin
      st_next.meter = rotate(st_reg.meter);
    end
    if (press[PIN_PHASE]) begin
      st_next.phase = rotate(st_reg.phase);
    end
    // Software writes come first so that hardware events below win.
    st_next.ack = 1'b0;
    if (cyc_in && stb_in && !st_reg.ack) begin
      st_next.ack = 1'b1;
      st_next.rdat = 32'h0000_0000;
      unique case (adr_in)
        OFF_CTRL: begin
          st_next.rdat = {31'h0, st_reg.run};
          wval = merge({31'h0, st_reg.run}, dat_in, sel_in);
          if (we_in) begin
            st_next.run = wval[0] && st_reg.fault == 16'h0000;
          end
        end
        OFF_FAULT: begin
          st_next.rdat = {16'h0000, st_reg.fault};
          wval = merge({16'h0000, st_reg.fault}, dat_in, sel_in);
          if (we_in) begin
            st_next.fault = wval[15:0];
            if (wval[15:0] != 16'h0000) begin
              st_next.run = 1'b0;
            end
          end
        end
        OFF_VSET: st_next.rdat = {4'h0, st_reg.vstore, 4'h0, st_reg.vlive};
        OFF_FSET: st_next.rdat = {4'h0, st_reg.fstore, 4'h0, st_reg.flive};
        OFF_ILIM: st_next.rdat = {4'h0, st_reg.ieff, 4'h0, st_reg.ilim};
        OFF_VLIM: begin
          st_next.rdat = {4'h0, st_reg.vhi_lim, 4'h0, st_reg.vlo_lim};
          wval = merge(st_next.rdat, dat_in, sel_in);
          if (we_in) begin
            st_next.vlo_lim = wval[11:0];
            st_next.vhi_lim = wval[27:16];
          end
        end
        OFF_STATUS: begin
          st_next.rdat = {16'h0000, st_reg.adj, st_reg.phase, st_reg.meter, st_reg.reject, st_reg.on,
                          st_reg.run, st_reg.range_hi};
          if (we_in && sel_in[0] && dat_in[ST_REJECT]) begin
            st_next.reject = 1'b0;
          end
        end
        default: st_next.rdat = 32'h0000_0000;
      endcase
    end
    if (press[PIN_RANGE] && !range_ok) begin
      st_next.reject = 1'b1;
    end
    // (R13) Overcurrent shutdown posts its trip code.
    if (st_next.lvl[PIN_OVERCUR] && !st_reg.lvl[PIN_OVERCUR]) begin
      st_next.fault = OVERCURRENT_TRIP_CODE;
      st_next.run = 1'b0;
    end
    // (R7) Output held off during the range drop-out.
    st_next.on = st_next.run && st_next.drop == 32'h0;
    // (R16) Off value falls back to rated capacity, halved in the high range.
    st_next.ieff = (st_next.ilim == ILIM_OFF) ? (st_next.range_hi ? RATED_CUR >> 1 : RATED_CUR) : st_next.ilim;
    // (R20) Combined view averages all but power, which is totalled.
    st_next.vdisp = (!st_next.run || st_next.adj == ADJ_VOLT) ? {4'h0, st_next.vlive} :
                    pick(meas_volt_in, st_next.phase, 1'b0);
    st_next.cdisp = (st_next.adj == ADJ_CUR) ? {4'h0, st_next.ilim} : pick(meas_cur_in, st_next.phase, 1'b0);
    st_next.fdisp = (st_next.fault != 16'h0000) ? st_next.fault : {4'h0, st_next.flive};
    st_next.ferr = st_next.fault != 16'h0000;
    st_next.rled = {st_next.range_hi, !st_next.range_hi};
    // (R18) Program step view packs set then step.
    unique case (st_next.meter)
      4'b0001: st_next.mdisp = pick(meas_pow_in, st_next.phase, 1'b1);
      4'b0010: st_next.mdisp = pick(meas_pf_in, st_next.phase, 1'b0);
      4'b0100: st_next.mdisp = test_time_in;
      default: st_next.mdisp = {4'h0, prog_set_in, 4'h0, prog_step_in};
    endcase
    // (R21) Banner on voltage and current displays.
    if (st_next.boot != 32'h0) begin
      st_next.vdisp = MODEL_NUM;
      st_next.cdisp = FW_VERSION;
    end
    // (R24) Blank the display that confirms its stored setting.
    st_next.vblank = st_next.flash != 32'h0 && !st_next.flash_freq;
    st_next.fblank = st_next.flash != 32'h0 && st_next.flash_freq;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      // (R22) Standby with output off after power-up.
      st_reg <= '0;
      st_reg.adj <= ADJ_NONE;
      st_reg.rep_btn <= PIN_NONE;
      st_reg.boot <= BOOT_CYC;
      st_reg.flive <= FREQ_PRESET;
      st_reg.fstore <= FREQ_PRESET;
      st_reg.vhi_lim <= VMAX_HI;
      st_reg.range_hi <= 1'b1;
      st_reg.rled <= 2'b10;
      st_reg.meter <= ONEHOT_FIRST;
      st_reg.phase <= ONEHOT_FIRST;
      st_reg.ieff <= RATED_CUR >> 1;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign dat_out = st_reg.rdat;
  assign ack_out = st_reg.ack;
  assign volt_disp_out = st_reg.vdisp;
  assign freq_disp_out = st_reg.fdisp;
  assign cur_disp_out = st_reg.cdisp;
  assign meter_disp_out = st_reg.mdisp;
  assign volt_blank_out = st_reg.vblank;
  assign freq_blank_out = st_reg.fblank;
  assign freq_err_out = st_reg.ferr;
  assign range_led_out = st_reg.rled;
  assign meter_led_out = st_reg.meter;
  assign phase_led_out = st_reg.phase;
  assign output_on_out = st_reg.on;
  assign vset_out = st_reg.vlive;
  assign fset_out = st_reg.flive;
  assign cur_limit_eff_out = st_reg.ieff;

  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_volt_in_range: assert property (vset_out <= (range_led_out[1] ? VMAX_HI : VMAX_LO)) // (R2)
    else $error("voltage setpoint outside active range");
  a_no_auto_hi: assert property (ce_in && !st_reg.range_hi && !press[PIN_RANGE] |=> !st_reg.range_hi) // (R5)
    else $error("range rose without a press");
  a_range_drop: assert property (ce_in && press[PIN_RANGE] && range_ok && st_reg.run |=> !output_on_out) // (R7)
    else $error("output not dropped on range change");
  a_range_refused: assert property (ce_in && press[PIN_RANGE] && !range_ok |=> $stable(range_led_out) && st_reg.reject) // (R8)
    else $error("range change not refused");
  a_preset_load: assert property (ce_in && press[PIN_FPRESET] |=> fset_out == FREQ_PRESET) // (R10)
    else $error("preset did not load");
  a_cur_first_show: assert property (ce_in && fire && fire_btn == PIN_IUP && st_reg.adj != ADJ_CUR
                                     |=> $stable(st_reg.ilim) && st_reg.adj == ADJ_CUR) // (R14)
    else $error("first current press changed the limit");
  a_oc_code: assert property (ce_in && st_next.lvl[PIN_OVERCUR] && !st_reg.lvl[PIN_OVERCUR]
                              |=> freq_disp_out == OVERCURRENT_TRIP_CODE && !output_on_out) // (R13)
    else $error("overcurrent code not shown");
  a_meter_rotate: assert property (ce_in && press[PIN_METER] |=> meter_led_out == rotate($past(meter_led_out))) // (R17)
    else $error("meter view did not advance");
  a_volt_commit: assert property (ce_in && st_reg.adj == ADJ_VOLT && st_reg.idle <= 32'h1 && !fire
                                  |=> volt_blank_out && st_reg.vstore == $past(vset_out)) // (R4)
    else $error("voltage idle commit missing");
  a_startup_off: assert property ($fell(reset_in) && ce_in |-> !output_on_out ##1 volt_disp_out == MODEL_NUM) // (R22)
    else $error("power-up not in standby banner");

  c_volt_commit: cover property (st_reg.adj == ADJ_VOLT ##1 st_reg.adj == ADJ_NONE);
  c_range_reject: cover property ($rose(st_reg.reject));
  c_overcurrent: cover property ($rose(freq_err_out));
  c_cur_adjust: cover property (st_reg.adj == ADJ_CUR && $changed(st_reg.ilim));
endmodule
`default_nettype wire

// >>> verif/panel_operator.sv
`timescale 1ns/1ps
`default_nettype none
module panel_operator (
  // Request from the bench
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [3:0] pin_in,
  input wire logic [15:0] len_in,
  // Front panel contacts
  output logic [10:0] pins_out,
  output logic busy_out
);
  logic [15:0] left_reg = 16'h0000;
  // One finger at a time: the button stays down for the whole count, then all contacts open.
  initial pins_out = 11'h000;
  always @(posedge clk_in) begin
    if (go_in) begin
      pins_out <= 11'h001 << pin_in;
      left_reg <= len_in;
    end else if (left_reg > 16'h0001) begin
      left_reg <= left_reg - 16'h0001;
    end else begin
      pins_out <= 11'h000;
      left_reg <= 16'h0000;
    end
  end
  assign busy_out = (left_reg != 16'h0000);
endmodule
`default_nettype wire

// >>> verif/front_panel_setpoint_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module front_panel_setpoint_control_bench;
  import panel_pkg::*;
  localparam logic [15:0] MODEL = 16'h2A5C;
  localparam logic [15:0] FW = 16'h0305;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, ce = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF, pin = 4'h0, em = 4'h1, ep = 4'h1;
  logic [15:0] len = 16'h0000;
  logic [31:0] wdat = 32'h0, rd, lfsr = 32'h4D3B;
  logic [47:0] mv = 48'h0, mc = 48'h0, mf = 48'h0, mp = 48'h0;
  logic [15:0] tt = 16'h0000;
  logic [3:0] pset = 4'h0, pstep = 4'h0;
  logic [31:0] dat_out;
  logic [15:0] vdisp, fdisp, cdisp, mdisp;
  logic [11:0] vset, fset, ieff;
  logic [10:0] pins;
  logic [3:0] mled, pled;
  logic [1:0] rled;
  logic ack, vblank, fblank, ferr, on, busy;
  int n_mismatch = 0, compares = 0, k, j, n;
  always #12.5 clk_in = ~clk_in;
  panel_operator op (.clk_in(clk_in), .go_in(go), .pin_in(pin), .len_in(len), .pins_out(pins), .busy_out(busy));
  panel_setpoint_ctrl #(.STEP_CYC(40), .MIN_STEP_CYC(5), .IDLE_CYC(100), .DROP_CYC(20), .FLASH_CYC(10),
    .BOOT_CYC(10), .RATED_CUR(12'h0C8), .MODEL_NUM(MODEL), .FW_VERSION(FW)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .cyc_in(cyc), .stb_in(stb), .we_in(we), .adr_in(adr),
    .sel_in(sel), .dat_in(wdat), .dat_out(dat_out), .ack_out(ack), .pins_in(pins), .meas_volt_in(mv),
    .meas_cur_in(mc), .meas_pf_in(mf), .meas_pow_in(mp), .test_time_in(tt),
    .prog_set_in(pset), .prog_step_in(pstep), .volt_disp_out(vdisp), .freq_disp_out(fdisp),
    .cur_disp_out(cdisp), .meter_disp_out(mdisp), .volt_blank_out(vblank), .freq_blank_out(fblank),
    .freq_err_out(ferr), .range_led_out(rled), .meter_led_out(mled), .phase_led_out(pled),
    .output_on_out(on), .vset_out(vset), .fset_out(fset), .cur_limit_eff_out(ieff));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Single phase reading, or the combined view: power totalled and saturated, the rest averaged.
  function automatic logic [15:0] view_exp(input logic [47:0] m, input logic [3:0] ph, input logic total);
    logic [17:0] s;
    s = m[15:0] + m[31:16] + m[47:32];
    if (ph[3]) begin
      return total ? ((s > 18'h0FFFF) ? 16'hFFFF : s[15:0]) : 16'(s / 18'h00003);
    end
    return ph[0] ? m[15:0] : (ph[1] ? m[31:16] : m[47:32]);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk_in); c++; end while (ack !== 1'b1 && c < 40);
    rd = dat_out;
    cyc <= 1'b0; stb <= 1'b0;
    if (c >= 40) check(32'h0, 32'h1);
    @(posedge clk_in);
  endtask
  task automatic press(input logic [3:0] p, input logic [15:0] l);
    int c;
    c = 0;
    pin <= p; len <= l; go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    do begin @(posedge clk_in); c++; end while (busy && c < 5000);
    repeat (8) @(posedge clk_in);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check(vdisp, MODEL);
    check(cdisp, FW);
    check({on, rled}, 3'b010);
    // With the limit off the high range gets half the rated current.
    check(ieff, 12'h064);
    repeat (15) @(posedge clk_in);
    press(PIN_VUP, 16'd50);
    check(vset, 32'h2);
    n = 0;
    while (vblank !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    check(vblank, 1'b1);
    wb(1'b0, OFF_VSET, 32'h0);
    check(rd[27:16], 32'h2);
    press(PIN_FUP, 16'd10);
    check(fset, 32'h191);
    press(PIN_FDN, 16'd50);
    check(fdisp, 32'h18F);
    press(PIN_FPRESET, 16'd10);
    check(fset, FREQ_PRESET);
    $display("setpoint tests done");
    for (k = 0; k < 6; k++) begin
      lfsr = lfsr_next(lfsr);
      mv <= {lfsr[15:0], lfsr};
      mc <= {lfsr, lfsr[31:16]};
      mf <= {lfsr[7:0], lfsr, lfsr[31:24]};
      mp <= ~{lfsr[15:0], lfsr};
      tt <= lfsr[31:16];
      pset <= lfsr[7:4];
      pstep <= lfsr[11:8];
      for (j = 0; j <= lfsr[1:0]; j++) begin
        press(PIN_METER, 16'd6);
        em = {em[2:0], em[3]};
      end
      for (j = 0; j <= lfsr[3:2]; j++) begin
        press(PIN_PHASE, 16'd6);
        ep = {ep[2:0], ep[3]};
      end
      check(mled, em);
      check(pled, ep);
      check(cdisp, view_exp(mc, ep, 1'b0));
      if (em == 4'h1) check(mdisp, view_exp(mp, ep, 1'b1));
      if (em == 4'h2) check(mdisp, view_exp(mf, ep, 1'b0));
      if (em == 4'h4) check(mdisp, tt);
      if (em == 4'h8) check(mdisp, {4'h0, pset, 4'h0, pstep});
    end
    // A press made while the clock enable is low must leave no trace.
    ce <= 1'b0;
    press(PIN_METER, 16'd6);
    ce <= 1'b1;
    repeat (8) @(posedge clk_in);
    check(mled, em);
    $display("view tests done");
    press(PIN_IUP, 16'd6);
    wb(1'b0, OFF_ILIM, 32'h0);
    check(rd[11:0], 32'h0);
    press(PIN_IUP, 16'd6);
    check(ieff, 32'h1);
    repeat (200) @(posedge clk_in);
    wb(1'b0, OFF_STATUS, 32'h0);
    check(rd[15:12], 32'h1);
    $display("current tests done");
    wb(1'b1, OFF_VLIM, 32'h0BB8_0600);
    press(PIN_RANGE, 16'd6);
    check(rled, 2'b10);
    wb(1'b0, OFF_STATUS, 32'h0);
    check(rd[3], 1'b1);
    wb(1'b1, OFF_STATUS, 32'h8);
    wb(1'b1, OFF_VLIM, 32'h0BB8_0000);
    wb(1'b1, OFF_CTRL, 32'h1);
    check(on, 1'b1);
    pin <= PIN_RANGE;
    len <= 16'd6;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    n = 0;
    repeat (60) begin
      @(posedge clk_in);
      if (on !== 1'b1) n++;
    end
    check(n, 32'd20);
    check({rled, vset}, {2'b01, 12'h002});
    check(vdisp, view_exp(mv, ep, 1'b0));
    $display("range tests done");
    press(PIN_OVERCUR, 16'd6);
    check({ferr, on, fdisp}, {2'b10, OVERCURRENT_TRIP_CODE});
    wb(1'b0, 8'h40, 32'h0); check(rd, 32'h0);
    $display("fault and bus tests done");
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
